// [hdl/sdc_chan.sv]
// DMA channel with abort, chaining, prefetch and pause handling, APB registers
//
// Summary of operation
// - A destination-synced channel, or a source-synced one with buffering_off set, that takes a write error on its last element disables itself.
// - A write error before the block ends makes the channel abort cleanly and then disable.
// - With dest_burst_on set, writes are issued as bursts even when started by a link after an earlier abort.
// - The channel is software synchronized when both sync select fields are zero.
// - Destination sync with prefetch means side select zero, at least one nonzero sync select field and prefetch set.
// - A chained channel that is not the chain head starts its read when the link enables it.
// - A hardware request arriving before the first read response never causes a write with no byte enables nor upsets the counters.
// - The abort path is taken on disable mid-transfer without drain, on a write error before block end, or on a read error without drain.
// - Clearing the pause bit lets a chained channel carry on loading its descriptor.
`timescale 1ns/10ps
module sdc_chan
    import sdc_pkg::*;
#(
    parameter int unsigned DW = DATA_W
)
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [DW-1:0]      pwdata,
    output logic      [DW-1:0]      prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    output logic                    rd_req,
    output logic      [31:0]        rd_addr,
    input  wire logic               rd_rsp_valid,
    input  wire logic [DW-1:0]      rd_rsp_data,
    input  wire logic               rd_rsp_err,
    output logic                    wr_req,
    output logic      [31:0]        wr_addr,
    output logic      [DW-1:0]      wr_data,
    output logic      [DW/8-1:0]    wr_be,
    output logic                    wr_burst,
    output logic                    wr_last,
    input  wire logic               wr_ack,
    input  wire logic               wr_err,
    input  wire logic               hw_transfer_request,
    input  wire logic               link_en_in,
    output logic                    link_en_out,
    output logic                    chan_active
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DW != 32)
    begin : g_bad_dw
        $error("sdc_chan: only a 32-bit data path is supported");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sdc_evt_if evt ();

    logic [31:0]      ctrl_q;
    logic [CNT_W-1:0] elem_cfg_q;
    logic [CNT_W-1:0] frame_cfg_q;
    logic [31:0]      src_q;
    logic [31:0]      dst_q;
    logic             pready_q;
    logic             pslverr_q;
    logic [DW-1:0]    prdata_q;
    logic [DW-1:0]    rd_mux;
    logic             reg_hit;
    logic             setup;
    logic             wr_acc;
    sdc_state_t       st_q;
    logic [CNT_W-1:0] elem_left_q;
    logic [CNT_W-1:0] frame_left_q;
    logic [31:0]      rd_addr_q;
    logic [31:0]      wr_addr_q;
    logic [DW-1:0]    data_q;
    logic             rd_req_q;
    logic             wr_req_q;
    logic [DW/8-1:0]  wr_be_q;
    logic             wr_burst_q;
    logic             wr_last_q;
    logic             link_out_q;
    logic             active_q;
    logic             aborted_q;
    logic             hw_s1_q;
    logic             hw_s2_q;
    logic             hw_s3_q;
    logic             hw_pend_q;
    logic             hw_take;
    logic             hw_dis;
    logic [EV_N-1:0]  ev_d;
    logic             en;
    logic             last_el;
    logic             may_read;
    logic             may_write;
    logic             bad_desc;

    assign en        = ctrl_q[EN_BIT];
    assign last_el   = (elem_left_q == CNT_W'(1)) && (frame_left_q == CNT_W'(1));
    // Without prefetch a destination-synced channel waits for its request first
    assign may_read  = !sdc_dst_sync(ctrl_q) || sdc_dst_prefetch(ctrl_q)
                     || hw_pend_q;
    assign may_write = sdc_soft_sync(ctrl_q) || !sdc_dst_sync(ctrl_q)
                     || hw_pend_q;
    assign bad_desc  = (frame_cfg_q == '0) || (elem_cfg_q == '0)
                     || (src_q[1:0] != 2'h0) || (dst_q[1:0] != 2'h0);

    // ------------------------------------------------------------
    // APB slave: one wait-free access phase after each setup
    // ------------------------------------------------------------
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_q && pwrite;

    // Read mux and address decode
    always_comb
    begin
        reg_hit = 1'b1;
        rd_mux  = '0;
        case (paddr)
            OFF_CTRL:  rd_mux = ctrl_q;
            OFF_STAT:
            begin
                rd_mux[EV_N-1:0]   = evt.status;
                rd_mux[ACTIVE_BIT] = en;
                rd_mux[ABORTED_BIT] = aborted_q;
                rd_mux[DESC_BIT]   = (st_q == ST_DESC);
            end
            OFF_MASK:  rd_mux[EV_N-1:0] = evt.mask;
            OFF_ELEM:  rd_mux[CNT_W-1:0] = elem_cfg_q;
            OFF_FRAME: rd_mux[CNT_W-1:0] = frame_cfg_q;
            OFF_SRC:   rd_mux = src_q;
            OFF_DST:   rd_mux = dst_q;
            default:   reg_hit = 1'b0;
        endcase
    end

    // Answer prepared during setup, presented in the access phase
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !reg_hit;
            prdata_q  <= (setup && !pwrite) ? rd_mux : '0;
        end
    end

    // Plain configuration registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            elem_cfg_q  <= '0;
            frame_cfg_q <= '0;
            src_q       <= '0;
            dst_q       <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == OFF_ELEM)
                elem_cfg_q <= pwdata[CNT_W-1:0];
            if (paddr == OFF_FRAME)
                frame_cfg_q <= pwdata[CNT_W-1:0];
            if (paddr == OFF_SRC)
                src_q <= pwdata;
            if (paddr == OFF_DST)
                dst_q <= pwdata;
        end
    end

    // Control register: software write first, then hardware disable, then link
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_q <= CTRL_RST;
        else if (wr_acc && (paddr == OFF_CTRL))
            ctrl_q <= pwdata;
        else if (hw_dis)
            ctrl_q[EN_BIT] <= 1'b0;
        else if (link_en_in && ctrl_q[CHAIN_BIT] && !ctrl_q[HEAD_BIT])
            ctrl_q[EN_BIT] <= 1'b1;
    end

    // Status clear and mask writes go to the sticky block
    assign evt.clr_we   = wr_acc && (paddr == OFF_STAT);
    assign evt.clr_val  = pwdata[EV_N-1:0];
    assign evt.mask_we  = wr_acc && (paddr == OFF_MASK);
    assign evt.mask_val = pwdata[EV_N-1:0];
    assign evt.ev       = ev_d;

    sdc_irq u_irq (
        .clk (clk),
        .rst (rst),
        .evt (evt)
    );

    // ------------------------------------------------------------
    // Hardware request: pin synchroniser and pending flag
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hw_s1_q <= 1'b0;
            hw_s2_q <= 1'b0;
            hw_s3_q <= 1'b0;
        end
        else
        begin
            hw_s1_q <= hw_transfer_request;
            hw_s2_q <= hw_s1_q;
            hw_s3_q <= hw_s2_q;
        end
    end

    // An early request is only remembered; it is spent by a real write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hw_pend_q <= 1'b0;
        else if (hw_s2_q && !hw_s3_q)
            hw_pend_q <= 1'b1;
        else if (hw_take)
            hw_pend_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Channel sequencing: events and hardware disable
    // ------------------------------------------------------------
    always_comb
    begin
        ev_d    = '0;
        hw_dis  = 1'b0;
        hw_take = 1'b0;
        case (st_q)
            ST_DESC:
            begin
                if (bad_desc)
                begin
                    ev_d[EV_MISALIGN] = 1'b1;
                    hw_dis            = 1'b1;
                end
            end
            ST_RD:
            begin
                if (rd_req_q && rd_rsp_valid && rd_rsp_err)
                    ev_d[EV_RD_ERR] = 1'b1;
            end
            ST_HOLD:
                hw_take = may_write && sdc_dst_sync(ctrl_q);
            ST_WR:
            begin
                if (wr_ack && wr_err)
                begin
                    ev_d[EV_WR_ERR] = 1'b1;
                    hw_dis          = last_el;
                end
            end
            ST_ABORT:
            begin
                ev_d[EV_ABORT] = 1'b1;
                hw_dis         = 1'b1;
            end
            ST_DONE:
            begin
                ev_d[EV_DONE] = 1'b1;
                hw_dis        = 1'b1;
            end
            default:
                hw_dis = 1'b0;
        endcase
    end

    // State, counters and transfer ports
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q         <= ST_IDLE;
            elem_left_q  <= '0;
            frame_left_q <= '0;
            rd_addr_q    <= '0;
            wr_addr_q    <= '0;
            data_q       <= '0;
            rd_req_q     <= 1'b0;
            wr_req_q     <= 1'b0;
            wr_be_q      <= '0;
            wr_burst_q   <= 1'b0;
            wr_last_q    <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_IDLE:
                begin
                    if (en)
                        st_q <= ST_DESC;
                end
                ST_DESC:
                begin
                    // Pause holds the load; clearing it resumes here
                    if (bad_desc)
                        st_q <= ST_IDLE;
                    else if (!ctrl_q[PAUSE_BIT])
                    begin
                        elem_left_q  <= elem_cfg_q;
                        frame_left_q <= frame_cfg_q;
                        rd_addr_q    <= src_q;
                        wr_addr_q    <= dst_q;
                        st_q         <= ST_RD;
                    end
                end
                ST_RD:
                begin
                    if (!rd_req_q)
                    begin
                        if (!en)
                            st_q <= ST_IDLE;
                        else if (may_read)
                            rd_req_q <= 1'b1;
                    end
                    else if (rd_rsp_valid)
                    begin
                        // Disable or error with nothing buffered: no drain
                        rd_req_q <= 1'b0;
                        data_q   <= rd_rsp_data;
                        st_q     <= (rd_rsp_err || !en) ? ST_ABORT
                                                        : ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    // Only buffered data is ever written, so enables are full
                    if (may_write)
                    begin
                        wr_req_q   <= 1'b1;
                        wr_be_q    <= '1;
                        wr_burst_q <= ctrl_q[BURST_BIT];
                        wr_last_q  <= last_el;
                        st_q       <= ST_WR;
                    end
                end
                ST_WR:
                begin
                    if (wr_ack)
                    begin
                        wr_req_q  <= 1'b0;
                        wr_last_q <= 1'b0;
                        rd_addr_q <= rd_addr_q + 32'h0000_0004;
                        wr_addr_q <= wr_addr_q + 32'h0000_0004;
                        if (elem_left_q == CNT_W'(1))
                        begin
                            elem_left_q  <= elem_cfg_q;
                            frame_left_q <= frame_left_q - CNT_W'(1);
                        end
                        else
                            elem_left_q <= elem_left_q - CNT_W'(1);
                        if (wr_err)
                            st_q <= last_el ? ST_IDLE : ST_ABORT;
                        else if (last_el)
                            st_q <= ST_DONE;
                        else
                            st_q <= en ? ST_RD : ST_IDLE;
                    end
                end
                ST_ABORT:
                    st_q <= ST_IDLE;
                ST_DONE:
                    st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // Abort history: kept until a clean completion or a rejected descriptor
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            aborted_q <= 1'b0;
        else if (st_q == ST_ABORT)
            aborted_q <= 1'b1;
        else if ((st_q == ST_DONE) || ((st_q == ST_DESC) && bad_desc))
            aborted_q <= 1'b0;
    end

    // Chain link pulse and activity flag
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            link_out_q <= 1'b0;
            active_q   <= 1'b0;
        end
        else
        begin
            link_out_q <= (st_q == ST_DONE) && ctrl_q[CHAIN_BIT];
            active_q   <= (st_q != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign irq         = evt.irq;
    assign rd_req      = rd_req_q;
    assign rd_addr     = rd_addr_q;
    assign wr_req      = wr_req_q;
    assign wr_addr     = wr_addr_q;
    assign wr_data     = data_q;
    assign wr_be       = wr_be_q;
    assign wr_burst    = wr_burst_q;
    assign wr_last     = wr_last_q;
    assign link_en_out = link_out_q;
    assign chan_active = active_q;

endmodule : sdc_chan

// [pkg/sdc_pkg.sv]
// Shared constants, types and decode helpers for the DMA channel control block
package sdc_pkg;

    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int unsigned PADDR_W   = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned CNT_W     = 16;
    localparam logic [7:0]  OFF_CTRL  = 8'h00;   // channel_control_reg
    localparam logic [7:0]  OFF_STAT  = 8'h04;   // channel_status_reg
    localparam logic [7:0]  OFF_MASK  = 8'h08;
    localparam logic [7:0]  OFF_ELEM  = 8'h0C;
    localparam logic [7:0]  OFF_FRAME = 8'h10;   // frame_count
    localparam logic [7:0]  OFF_SRC   = 8'h14;
    localparam logic [7:0]  OFF_DST   = 8'h18;

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int unsigned SYNC_LO_LSB  = 0;    // sync_select_low, 5 bits
    localparam int unsigned SYNC_LO_W    = 5;
    localparam int unsigned EN_BIT       = 7;
    localparam int unsigned PAUSE_BIT    = 8;
    localparam int unsigned HEAD_BIT     = 9;
    localparam int unsigned CHAIN_BIT    = 10;
    localparam int unsigned BURST_BIT    = 11;   // dest_burst_on
    localparam int unsigned SYNC_HI_LSB  = 19;   // sync_select_high, 2 bits
    localparam int unsigned SYNC_HI_W    = 2;
    localparam int unsigned PREFETCH_BIT = 23;
    localparam int unsigned SIDE_BIT     = 24;   // sync_side_select, 0 = destination
    localparam int unsigned BUFOFF_BIT   = 25;   // buffering_off
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Status layout and events
    // ------------------------------------------------------------
    localparam int unsigned EV_DONE     = 0;
    localparam int unsigned EV_RD_ERR   = 1;
    localparam int unsigned EV_WR_ERR   = 2;
    localparam int unsigned EV_ABORT    = 3;
    localparam int unsigned EV_MISALIGN = 4;
    localparam int unsigned EV_N        = 5;
    localparam int unsigned ACTIVE_BIT  = 7;
    localparam int unsigned ABORTED_BIT = 14;
    localparam int unsigned DESC_BIT    = 15;
    localparam logic [EV_N-1:0] MASK_RST = 5'h00;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DESC, ST_RD, ST_HOLD, ST_WR, ST_ABORT, ST_DONE
    } sdc_state_t;

    // Software synchronized when both sync select fields are zero
    function automatic logic sdc_soft_sync(input logic [31:0] c);
        sdc_soft_sync = (c[SYNC_LO_LSB +: SYNC_LO_W] == 5'h00)
                      && (c[SYNC_HI_LSB +: SYNC_HI_W] == 2'h0);
    endfunction : sdc_soft_sync

    // Hardware synchronized at the destination side
    function automatic logic sdc_dst_sync(input logic [31:0] c);
        sdc_dst_sync = !sdc_soft_sync(c) && (c[SIDE_BIT] == 1'b0);
    endfunction : sdc_dst_sync

    // Destination sync with prefetch selected
    function automatic logic sdc_dst_prefetch(input logic [31:0] c);
        sdc_dst_prefetch = sdc_dst_sync(c) && (c[PREFETCH_BIT] == 1'b1);
    endfunction : sdc_dst_prefetch

endpackage : sdc_pkg

// [pkg/sdc_evt_if.sv]
// Event, clear and mask signals between the channel core and its status block
`timescale 1ns/10ps
interface sdc_evt_if;
    import sdc_pkg::*;
    logic [EV_N-1:0] ev;
    logic            clr_we;
    logic [EV_N-1:0] clr_val;
    logic            mask_we;
    logic [EV_N-1:0] mask_val;
    logic [EV_N-1:0] status;
    logic [EV_N-1:0] mask;
    logic            irq;
    modport core   (output ev, clr_we, clr_val, mask_we, mask_val,
                    input status, mask, irq);
    modport sticky (input ev, clr_we, clr_val, mask_we, mask_val,
                    output status, mask, irq);
endinterface : sdc_evt_if

// [hdl/sdc_irq.sv]
// Sticky event status, interrupt mask and level interrupt
`timescale 1ns/10ps
module sdc_irq
    import sdc_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    sdc_evt_if.sticky evt
);

    logic [EV_N-1:0] status_q;
    logic [EV_N-1:0] mask_q;
    logic            irq_q;

    // Sticky bits: a new event wins over a write-one-to-clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            status_q <= '0;
        else if (evt.clr_we)
            status_q <= (status_q & ~evt.clr_val) | evt.ev;
        else
            status_q <= status_q | evt.ev;
    end

    // Mask register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            mask_q <= MASK_RST;
        else if (evt.mask_we)
            mask_q <= evt.mask_val;
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_q & mask_q);
    end

    assign evt.status = status_q;
    assign evt.mask   = mask_q;
    assign evt.irq    = irq_q;

endmodule : sdc_irq

// [verification/sdc_chan_properties.sv]
// Port-level checks on the DMA channel
`timescale 1ns/10ps
module sdc_chan_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       rd_req,
    input wire logic       rd_rsp_valid,
    input wire logic       rd_rsp_err,
    input wire logic       wr_req,
    input wire logic [3:0] wr_be,
    input wire logic       wr_ack,
    input wire logic       wr_err,
    input wire logic       link_en_out,
    input wire logic       chan_active
);
    // One clock domain, so checks share one clock and stop during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");
    AST_BE_FULL: assert property (wr_req |-> wr_be == 4'hF)
        else $error("write without full byte enables");
    AST_ONE_OUT: assert property (!(rd_req && wr_req))
        else $error("read and write outstanding together");
    AST_WR_HOLD: assert property (wr_req && !wr_ack |=> wr_req)
        else $error("write dropped before ack");
    AST_RD_HOLD: assert property (rd_req && !rd_rsp_valid |=> rd_req)
        else $error("read dropped before response");
    AST_WR_ERR_STOP: assert property (wr_req && wr_ack && wr_err |=> !rd_req [*4])
        else $error("channel read on after write error");
    AST_RD_ERR_STOP: assert property (rd_req && rd_rsp_valid && rd_rsp_err |=> !wr_req [*4])
        else $error("channel wrote after read error");
    AST_ERR_IDLE: assert property (wr_req && wr_ack && wr_err |-> ##[1:8] !chan_active)
        else $error("channel still active after write error");
    AST_LINK_PULSE: assert property (link_en_out |=> !link_en_out)
        else $error("link enable longer than one cycle");
endmodule : sdc_chan_properties

// [verification/sdc_bus_model.sv]
// Interconnect read and write targets facing the channel
`timescale 1ns/10ps
module sdc_bus_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        rd_bad,
    input  wire logic        wr_bad,
    input  wire logic        rd_req,
    input  wire logic [31:0] rd_addr,
    input  wire logic        wr_req,
    output logic             rd_rsp_valid,
    output logic      [31:0] rd_rsp_data,
    output logic             rd_rsp_err,
    output logic             wr_ack,
    output logic             wr_err
);
    logic [2:0] wait_q;
    logic       hit;
    // Answer at once, or after four wait cycles when slow
    assign hit = (rd_req && !rd_rsp_valid || wr_req && !wr_ack) && wait_q >= {slow, 2'h0};
    // Read data toggles outside a response so a stale word never looks valid
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 3'h0;
            rd_rsp_valid <= 1'b0;
            rd_rsp_data <= 32'h0;
            rd_rsp_err <= 1'b0;
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
        end
        else
        begin
            wait_q <= (hit || !(rd_req || wr_req)) ? 3'h0 : wait_q + 3'h1;
            rd_rsp_valid <= hit && rd_req;
            rd_rsp_data <= hit ? rd_addr ^ 32'h5A5A_0000 : ~rd_rsp_data;
            rd_rsp_err <= hit && rd_req && rd_bad;
            wr_ack <= hit && wr_req;
            wr_err <= hit && wr_req && wr_bad;
        end
    end
endmodule : sdc_bus_model

// [verification/sdc_chan_test.sv]
// Self-checking bench for the DMA channel
`timescale 1ns/10ps
module sdc_chan_test;
    import sdc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic link_en_in = 1'b0, hw_transfer_request = 1'b0, slow = 1'b0, rd_bad = 1'b0;
    logic wr_bad = 1'b0, lnk = 1'b0, bad = 1'b0, burst, pready, pslverr, irq, rd_req;
    logic rd_rsp_valid, rd_rsp_err, wr_req, wr_ack, wr_err, wr_burst, wr_last;
    logic link_en_out, chan_active, se, lst;
    logic [7:0]  paddr = 8'h00, wn = 8'h00;
    logic [4:0]  cyc = 5'h00, msk = 5'h00;
    logic [3:0]  wr_be;
    logic [31:0] pwdata = 32'h0, prdata, rd_addr, rd_rsp_data, wr_addr, wr_data, rv, held;
    int          mismatches = 0, samples_checked = 0;
    sdc_chan uut (.*);
    sdc_bus_model far_end (.*);
    always #4 clk = ~clk;
    // Request pin toggles every 16 cycles; writes are counted, data and address checked
    always @(posedge clk)
    begin
        cyc <= cyc + 5'h01;
        hw_transfer_request <= cyc[4];
        if (rd_req && rd_rsp_valid) held <= rd_rsp_data;
        if (wr_req && wr_ack) {wn, burst, lst, bad} <= {wn + 8'h01, wr_burst, wr_last,
            bad | (wr_data !== held) | ((wr_addr ^ wr_data) !== 32'h5A5A_0300)};
        if (link_en_out) lnk <= 1'b1;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Bus cycle: setup, then access held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        se = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Start a channel (by link when enable is clear), wait for idle, check and clear status
    task automatic go(input logic [31:0] c, input logic [31:0] e, input logic [7:0] n);
        logic [7:0] w0;
        int         i;
        w0 = wn;
        apb(1'b1, OFF_CTRL, c);
        if (!c[EN_BIT])
        begin
            @(posedge clk);
            link_en_in <= 1'b1;
            @(posedge clk);
            link_en_in <= 1'b0;
        end
        repeat (4) @(posedge clk);
        for (i = 0; i < 600 && chan_active; i++) @(posedge clk);
        chk(chan_active, 1'b0);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rv & (32'h809E | e[0]), e);
        chk(wn - w0, n);
        chk(lst, e[0] || e == 32'h4);
        chk(irq, |(e[4:0] & msk));
        apb(1'b1, OFF_STAT, 32'h1F);
        apb(1'b0, OFF_STAT, 32'h0);
        chk({irq, rv[4:0]}, 32'h0);
    endtask : go
    task automatic wrap_up;
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // Watchdog well beyond the expected run
    initial
    begin
        #400000;
        mismatches++;
        wrap_up;
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rv, CTRL_RST);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk(rv, 32'h0);
        msk = 5'h1F;
        apb(1'b1, OFF_MASK, 32'h1F);
        apb(1'b1, OFF_SRC, 32'h100);
        apb(1'b1, OFF_DST, 32'h200);
        apb(1'b1, OFF_ELEM, 32'h2);
        apb(1'b1, OFF_FRAME, 32'h1);
        go(32'h880, 32'h1, 8'h2);
        apb(1'b1, OFF_CTRL, 32'h180);
        repeat (6) @(posedge clk);
        apb(1'b0, OFF_STAT, 32'h0);
        chk(rv[DESC_BIT], 1'b1);
        go(32'h80, 32'h1, 8'h2);
        wr_bad <= 1'b1;
        go(32'h80, 32'hC, 8'h1);
        {wr_bad, rd_bad} <= 2'b01;
        go(32'h80, 32'hA, 8'h0);
        rd_bad <= 1'b0;
        apb(1'b1, OFF_FRAME, 32'h0);
        go(32'h80, 32'h10, 8'h0);
        apb(1'b1, OFF_FRAME, 32'h1);
        slow <= 1'b1;
        go(32'h0080_0C01, 32'h1, 8'h2);
        chk({burst, lnk, bad}, 32'h6);
        {slow, wr_bad} <= 2'b01;
        apb(1'b1, OFF_ELEM, 32'h1);
        go(32'h81, 32'h4, 8'h1);
        apb(1'b1, OFF_CTRL, 32'h0);
        {wr_bad, msk} <= 6'h00;
        apb(1'b1, OFF_MASK, 32'h0);
        go(32'h80, 32'h1, 8'h1);
        go(32'h0000_0401, 32'h1, 8'h1);
        wrap_up;
    end
endmodule : sdc_chan_test
bind sdc_chan sdc_chan_properties chk_i (.*);
